// [wdg_pkg.sv]
package wdg_pkg;

	// Register location and layout
	localparam logic [7:0] WDG_ADDR = 8'hD8;
	localparam logic [7:0] WDG_REG_RESET = 8'hFE;
	localparam int WDG_ACT_BIT = 0;
	localparam int WDG_SR_BIT = 1;
	localparam int WDG_PER_LO = 2;
	localparam int WDG_PER_HI = 7;
	localparam int WDG_CNT_W = 7;
	localparam int WDG_PER_W = 6;

	// Counter values
	localparam logic [6:0] WDG_CNT_RESET = 7'h7F;
	localparam logic [6:0] WDG_CNT_EXPIRE = 7'h40;
	localparam logic [6:0] WDG_CNT_ONE = 7'h01;

	// Timing counts in internal clock cycles and instructions
	localparam int WDG_PRESC_CYCLES = 3072;
	localparam int WDG_STAB_CYCLES = 2048;
	localparam int WDG_GUARD_INSTR = 28;
	localparam int WDG_STAB_W = 11;
	localparam logic [10:0] WDG_STAB_LAST = 11'(WDG_STAB_CYCLES - 1);
	localparam logic [10:0] WDG_STAB_ONE = 11'h001;

	// Operating modes, Gray coded along stab, run, wait, stop
	typedef enum logic [1:0]
	{
		WDG_STAB = 2'h0,
		WDG_RUN = 2'h1,
		WDG_WAIT = 2'h3,
		WDG_STOP = 2'h2
	} wdg_mode_t;

	// Data-space register access from the CPU
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wdg_bus_t;

	// CPU and interrupt status seen by the watchdog
	typedef struct packed
	{
		logic stop_exec;
		logic instr_done;
		logic irq_req;
		logic nmi_req;
		logic nmi_pin;
		logic global_irq_enable;
	} wdg_cpu_t;

	// Reverses the period field between register and counter order
	function automatic logic [5:0] wdg_rev6(input logic [5:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 0; i < 6; i++)
		begin
			r[i] = v[5 - i];
		end
		return r;
	endfunction

endpackage

// [wdg_presc.sv]
`timescale 1ns/1ns
module wdg_presc
#(
	parameter int DIV = 3072
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic restart_i,
	input wire logic run_i,
	// Decrement strobe
	output logic tick_o
);
	localparam int CW = $clog2(DIV);

	typedef struct packed
	{
		logic [CW-1:0] cnt;
		logic tick;
	} wdg_presc_st_t;

	wdg_presc_st_t s_ff;
	wdg_presc_st_t nxt_s;

	generate
		if (DIV < 2)
		begin : g_bad
			$error("prescaler divide must be at least 2");
		end
	endgenerate

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.tick = 1'b0;
		if (restart_i)
		begin
			nxt_s.cnt = '0;
		end
		else if (run_i)
		begin
			if (s_ff.cnt == CW'(DIV - 1))
			begin
				nxt_s.cnt = '0;
				nxt_s.tick = 1'b1;
			end
			else
			begin
				nxt_s.cnt = s_ff.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign tick_o = s_ff.tick;
endmodule

// [wdg_guard.sv]
`timescale 1ns/1ns
module wdg_guard
#(
	parameter int N = 28
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Arm on activation, count retired instructions
	input wire logic arm_i,
	input wire logic instr_done_i,
	// Expiry reset may now be issued
	output logic open_o
);
	localparam int CW = $clog2(N + 1);

	typedef struct packed
	{
		logic [CW-1:0] cnt;
		logic open;
	} wdg_guard_st_t;

	wdg_guard_st_t s_ff;
	wdg_guard_st_t nxt_s;

	generate
		if (N < 1)
		begin : g_bad
			$error("guard instruction count must be at least 1");
		end
	endgenerate

	always_comb
	begin
		nxt_s = s_ff;
		if (arm_i)
		begin
			nxt_s.cnt = '0;
			nxt_s.open = 1'b0;
		end
		else if (instr_done_i && !s_ff.open)
		begin
			nxt_s.cnt = s_ff.cnt + CW'(1);
			if (s_ff.cnt == CW'(N - 1))
				nxt_s.open = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign open_o = s_ff.open;
endmodule

// [wdg_top.sv]
// Behaviour
// - Reset chip when count bit 6 falls.
// - Register write reloads and restarts countdown.
// - Software option: inactive until activation bit written.
// - Activation sticks until chip reset.
// - Hardware option: always active, bit reads one.
// - Hardware, no external control: STOP acts WAIT.
// - External control, pin low: STOP acts WAIT.
// - External control, pin high: freeze, real STOP.
// - Leaving STOP resumes count from held value.
// - Register resets to FEh, longest period.
// - Bit0 activation, bit1 SR, bits7..2 reversed.
// - Writing SR zero while active resets chip at once.
// - 64 periods, 3072 to 196608 cycles.
// - Inactive: free 7-bit timer, no reset.
// - At least 28 instructions before expiry reset.
// - Interrupts disabled: no wake from STOP/WAIT.
// - Watchdog reset reinitialises counter and register.
// - Restart after 2048-cycle stabilisation delay.
`timescale 1ns/1ns
module wdg_top
#(
	parameter bit HW_ACTIVATION = 1'b1,
	parameter bit EXT_STOP_CTRL = 1'b0,
	parameter int PRESC_CYCLES = wdg_pkg::WDG_PRESC_CYCLES,
	parameter int GUARD_INSTR = wdg_pkg::WDG_GUARD_INSTR
)
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// Data-space register access
	input wire wdg_pkg::wdg_bus_t BUS_I,
	output logic [7:0] RDATA_O,
	// CPU status
	input wire wdg_pkg::wdg_cpu_t CPU_I,
	// Chip control
	output logic CHIP_RST_O,
	output logic STOP_O,
	output logic WAIT_O,
	output logic ACTIVE_O
);
	import wdg_pkg::*;

	// Read value of the register while held in reset
	localparam logic [7:0] RDATA_RESET = WDG_REG_RESET | 8'(HW_ACTIVATION);

	// Register order to counter order
	function automatic logic [6:0] reg_to_cnt(input logic [7:0] v);
		return {v[WDG_SR_BIT], wdg_rev6(v[WDG_PER_HI:WDG_PER_LO])};
	endfunction

	// Counter order to register order
	function automatic logic [7:0] cnt_to_reg(input logic [6:0] c,
		input logic act);
		return {wdg_rev6(c[5:0]), c[6], act};
	endfunction

	typedef struct packed
	{
		wdg_mode_t mode;
		logic [6:0] cnt;
		logic active;
		logic exp_pend;
		logic [10:0] stab_cnt;
		logic rst_out;
		logic stop_out;
		logic wait_out;
		logic [7:0] rdata;
	} wdg_top_st_t;

	wdg_top_st_t s_ff;
	wdg_top_st_t nxt_s;

	logic tick;
	logic guard_open;
	logic guard_arm;
	logic presc_restart;
	logic presc_run;
	logic wr_hit;
	logic rd_hit;
	logic real_stop;
	logic wake;
	logic sw_reset;
	logic expire_reset;
	logic new_active;
	logic [6:0] load_val;
	logic in_stab;
	logic in_run;
	logic in_wait;
	logic in_stop;
	logic [6:0] cnt_dec;
	logic bit6_fall;

	generate
		if (WDG_CNT_W != WDG_PER_W + 1)
		begin : g_bad_layout
			$error("counter must be period bits plus one");
		end
		if (PRESC_CYCLES < 2)
		begin : g_bad_presc
			$error("PRESC_CYCLES must be at least 2");
		end
		if (GUARD_INSTR < 1)
		begin : g_bad_guard
			$error("GUARD_INSTR must be at least 1");
		end
	endgenerate

	// Decrement strobe, frozen outside run and wait
	wdg_presc #(
		.DIV(PRESC_CYCLES)
	) u_presc (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.restart_i(presc_restart),
		.run_i(presc_run),
		.tick_o(tick)
	);

	// Instruction guard after activation
	wdg_guard #(
		.N(GUARD_INSTR)
	) u_guard (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.arm_i(guard_arm),
		.instr_done_i(CPU_I.instr_done),
		.open_o(guard_open)
	);

	// Mode decode
	always_comb
	begin
		in_stab = (s_ff.mode == WDG_STAB);
		in_run = (s_ff.mode == WDG_RUN);
		in_wait = (s_ff.mode == WDG_WAIT);
		in_stop = (s_ff.mode == WDG_STOP);
	end

	// Countdown value and the falling edge of the top bit
	always_comb
	begin
		cnt_dec = s_ff.cnt - WDG_CNT_ONE;
		bit6_fall = s_ff.cnt[WDG_CNT_W - 1] && !cnt_dec[WDG_CNT_W - 1];
	end

	// Access decode, only while the CPU executes
	always_comb
	begin
		wr_hit = BUS_I.wr && (BUS_I.addr == WDG_ADDR) && in_run;
		rd_hit = BUS_I.rd && (BUS_I.addr == WDG_ADDR) && in_run;
	end

	// Write value in counter order
	always_comb
	begin
		load_val = reg_to_cnt(BUS_I.wdata);
		new_active = s_ff.active;
		if (wr_hit && !HW_ACTIVATION && BUS_I.wdata[WDG_ACT_BIT])
			new_active = 1'b1;
	end

	// Reset causes
	always_comb
	begin
		sw_reset = wr_hit && new_active
			&& !BUS_I.wdata[WDG_SR_BIT];
		expire_reset = s_ff.exp_pend && guard_open;
	end

	// STOP interpretation
	always_comb
	begin
		if (EXT_STOP_CTRL)
			real_stop = CPU_I.nmi_pin;
		else if (HW_ACTIVATION)
			real_stop = 1'b0;
		else
			real_stop = !s_ff.active;
	end

	// Wake needs interrupts globally enabled, NMI included
	always_comb
	begin
		wake = (in_wait || in_stop) && CPU_I.global_irq_enable
			&& (CPU_I.irq_req || CPU_I.nmi_req);
	end

	// Prescaler and guard control
	always_comb
	begin
		presc_run = !in_stab && !in_stop;
		presc_restart = wr_hit || in_stab;
		guard_arm = 1'b0;
		if (wr_hit && new_active && !s_ff.active)
			guard_arm = 1'b1;
		if (in_stab && HW_ACTIVATION)
			guard_arm = 1'b1;
	end

	// Next state
	always_comb
	begin
		nxt_s = s_ff;
		case (s_ff.mode)
			WDG_STAB:
			begin
				nxt_s.rst_out = 1'b1;
				nxt_s.stab_cnt = s_ff.stab_cnt + WDG_STAB_ONE;
				if (s_ff.stab_cnt == WDG_STAB_LAST)
				begin
					nxt_s.mode = WDG_RUN;
					nxt_s.rst_out = 1'b0;
					nxt_s.stab_cnt = '0;
				end
			end
			WDG_RUN:
			begin
				if (CPU_I.stop_exec)
				begin
					if (real_stop)
					begin
						nxt_s.mode = WDG_STOP;
						nxt_s.stop_out = 1'b1;
					end
					else
					begin
						nxt_s.mode = WDG_WAIT;
						nxt_s.wait_out = 1'b1;
					end
				end
			end
			WDG_WAIT:
			begin
				if (wake)
				begin
					nxt_s.mode = WDG_RUN;
					nxt_s.wait_out = 1'b0;
				end
			end
			WDG_STOP:
			begin
				if (wake)
				begin
					nxt_s.mode = WDG_RUN;
					nxt_s.stop_out = 1'b0;
				end
			end
			default:
			begin
				nxt_s.mode = WDG_STAB;
				nxt_s.stab_cnt = '0;
				nxt_s.rst_out = 1'b1;
			end
		endcase

		// Countdown
		if (tick)
		begin
			nxt_s.cnt = cnt_dec;
			if (s_ff.active && bit6_fall)
				nxt_s.exp_pend = 1'b1;
		end

		// Reload by write, ahead of the tick
		if (wr_hit)
		begin
			nxt_s.cnt = load_val;
			nxt_s.active = new_active;
		end

		// Read back in register order
		if (rd_hit)
		begin
			nxt_s.rdata = cnt_to_reg(s_ff.cnt, s_ff.active);
		end

		// Chip reset reinitialises all state except the read-back data
		if (sw_reset || expire_reset)
		begin
			nxt_s.mode = WDG_STAB;
			nxt_s.stab_cnt = '0;
			nxt_s.rst_out = 1'b1;
			nxt_s.cnt = WDG_CNT_RESET;
			nxt_s.active = HW_ACTIVATION;
			nxt_s.exp_pend = 1'b0;
			nxt_s.stop_out = 1'b0;
			nxt_s.wait_out = 1'b0;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			s_ff.mode <= WDG_STAB;
			s_ff.cnt <= WDG_CNT_RESET;
			s_ff.active <= HW_ACTIVATION;
			s_ff.exp_pend <= 1'b0;
			s_ff.stab_cnt <= '0;
			s_ff.rst_out <= 1'b1;
			s_ff.stop_out <= 1'b0;
			s_ff.wait_out <= 1'b0;
			s_ff.rdata <= RDATA_RESET;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	assign RDATA_O = s_ff.rdata;
	assign CHIP_RST_O = s_ff.rst_out;
	assign STOP_O = s_ff.stop_out;
	assign WAIT_O = s_ff.wait_out;
	assign ACTIVE_O = s_ff.active;
endmodule

// [wdg_properties.sv]
`timescale 1ns/1ns
module wdg_properties
import wdg_pkg::*;
#(
	parameter bit EXT_STOP_CTRL = 1'b0
)
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// Watched ports
	input wire wdg_pkg::wdg_bus_t BUS_I,
	input wire logic [7:0] RDATA_O,
	input wire wdg_pkg::wdg_cpu_t CPU_I,
	input wire logic CHIP_RST_O,
	input wire logic STOP_O,
	input wire logic WAIT_O,
	input wire logic ACTIVE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	logic [11:0] hi_ff;
	logic run;
	logic hit;
	assign run = !CHIP_RST_O && !STOP_O && !WAIT_O;
	assign hit = run && BUS_I.addr == WDG_ADDR;
	// Edges spent in chip reset
	always_ff @(posedge CLK_I or posedge RST_I)
		if (RST_I)
			hi_ff <= 12'h000;
		else
			hi_ff <= CHIP_RST_O ? hi_ff + 12'h001 : 12'h000;
	property p_stab;
		$fell(CHIP_RST_O) |-> hi_ff >= 12'h7FF && hi_ff <= 12'h802;
	endproperty
	a_stab: assert property (p_stab)
		else $error("stabilisation length wrong");
	property p_sr;
		hit && BUS_I.wr && !BUS_I.wdata[1] && (ACTIVE_O || BUS_I.wdata[0])
			|=> CHIP_RST_O;
	endproperty
	a_sr: assert property (p_sr)
		else $error("software reset missing");
	property p_inact;
		!ACTIVE_O && !CHIP_RST_O && !BUS_I.wr |=> !CHIP_RST_O;
	endproperty
	a_inact: assert property (p_inact)
		else $error("reset while inactive");
	property p_keep;
		ACTIVE_O && !CHIP_RST_O |=> ACTIVE_O || CHIP_RST_O;
	endproperty
	a_keep: assert property (p_keep)
		else $error("activation lost");
	property p_stop;
		EXT_STOP_CTRL && run && CPU_I.stop_exec && CPU_I.nmi_pin
			|=> STOP_O && !WAIT_O;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop not entered");
	property p_wait;
		EXT_STOP_CTRL && run && CPU_I.stop_exec && !CPU_I.nmi_pin
			|=> WAIT_O && !STOP_O;
	endproperty
	a_wait: assert property (p_wait)
		else $error("wait not entered");
	property p_nowake;
		(STOP_O || WAIT_O) && !CPU_I.global_irq_enable
			|=> STOP_O || WAIT_O || CHIP_RST_O;
	endproperty
	a_nowake: assert property (p_nowake)
		else $error("woke with interrupts off");
	property p_read;
		hit && BUS_I.rd && !BUS_I.wr |=> RDATA_O[0] == $past(ACTIVE_O);
	endproperty
	a_read: assert property (p_read)
		else $error("read activation bit wrong");
endmodule

// [wdg_cpu_mdl.sv]
`timescale 1ns/1ns
module wdg_cpu_mdl
(
	// Clock and run state
	input wire logic clk_i,
	input wire logic run_i,
	// Retired instruction pulse
	output logic instr_done_o
);
	// One instruction every other cycle while running
	initial instr_done_o = 1'b0;
	always @(posedge clk_i)
		instr_done_o <= run_i && !instr_done_o;
endmodule

// [wdg_top_tb.sv]
`timescale 1ns/1ns
module wdg_top_tb;
	import wdg_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	wdg_bus_t bus = '0;
	logic stp = 1'b0;
	logic irq = 1'b0;
	logic nmi = 1'b0;
	logic gen = 1'b0;
	logic idone;
	wdg_cpu_t cpu;
	logic [7:0] rdata;
	logic chip_rst;
	logic stop_o;
	logic wait_o;
	logic active;
	int mismatches = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'h4B2EDB52;
	assign cpu = '{stp, idone, irq, 1'b0, nmi, gen};
	always #10 clk = ~clk;
	wdg_top #(.HW_ACTIVATION(1'b0), .EXT_STOP_CTRL(1'b1), .PRESC_CYCLES(8),
		.GUARD_INSTR(2)) dut_u (.CLK_I(clk), .RST_I(rst), .BUS_I(bus),
		.RDATA_O(rdata), .CPU_I(cpu), .CHIP_RST_O(chip_rst),
		.STOP_O(stop_o), .WAIT_O(wait_o), .ACTIVE_O(active));
	wdg_cpu_mdl cpu_u (.clk_i(clk), .run_i(!chip_rst && !stop_o && !wait_o),
		.instr_done_o(idone));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task op(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{w, !w, a, d};
		@(posedge clk);
		bus <= '{1'b0, 1'b0, a, d};
		#1;
	endtask
	task up;
		int i;
		i = 0;
		while (chip_rst !== 1'b0 && i < 3000)
		begin
			@(posedge clk);
			i++;
		end
		@(posedge clk);
	endtask
	task final_report;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (40000) @(posedge clk);
		mismatches++;
		final_report();
	end
	initial
	begin
		int n;
		logic [7:0] w;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		up();
		op(0, WDG_ADDR, 8'h00);
		chk(rdata, WDG_REG_RESET);
		op(0, 8'hD9, 8'h00);
		chk(rdata, WDG_REG_RESET);
		$display("reset test done");
		repeat (8)
		begin
			seed = lfsr(seed);
			w = {seed[7:1], 1'b0};
			op(1, WDG_ADDR, w);
			op(0, WDG_ADDR, 8'h00);
			chk(rdata, w);
			chk({7'h00, chip_rst}, 8'h00);
		end
		$display("inactive test done");
		for (int k = 0; k < 2; k++)
		begin
			op(1, WDG_ADDR, k ? 8'hA3 : 8'h03);
			n = 0;
			while (chip_rst !== 1'b1 && n < 200)
			begin
				@(posedge clk);
				#1;
				n++;
			end
			chk(8'(n >= (k ? 48 : 8) && n <= (k ? 51 : 11)), 8'h01);
			up();
			chk({7'h00, active}, 8'h00);
		end
		$display("expiry test done");
		op(1, WDG_ADDR, 8'h83);
		repeat (6)
		begin
			repeat (10) @(posedge clk);
			op(1, WDG_ADDR, 8'h82);
		end
		op(0, WDG_ADDR, 8'h00);
		chk(rdata, 8'h83);
		chk({7'h00, chip_rst}, 8'h00);
		op(1, WDG_ADDR, 8'h81);
		@(posedge clk);
		#1;
		chk({7'h00, chip_rst}, 8'h01);
		up();
		$display("reload test done");
		for (int k = 0; k < 2; k++)
		begin
			op(1, WDG_ADDR, 8'hFE);
			nmi <= (k == 0);
			stp <= 1'b1;
			@(posedge clk);
			stp <= 1'b0;
			irq <= 1'b1;
			repeat (30) @(posedge clk);
			#1;
			chk({6'h00, stop_o, wait_o}, k ? 8'h01 : 8'h02);
			@(posedge clk);
			gen <= 1'b1;
			@(posedge clk);
			gen <= 1'b0;
			irq <= 1'b0;
			#1;
			chk({6'h00, stop_o, wait_o}, 8'h00);
			if (k == 0)
			begin
				op(0, WDG_ADDR, 8'h00);
				chk(rdata, 8'hFE);
			end
		end
		$display("stop test done");
		final_report();
	end
endmodule
bind wdg_top wdg_properties #(.EXT_STOP_CTRL(EXT_STOP_CTRL)) chk_u (
	.CLK_I(CLK_I), .RST_I(RST_I), .BUS_I(BUS_I), .RDATA_O(RDATA_O),
	.CPU_I(CPU_I), .CHIP_RST_O(CHIP_RST_O), .STOP_O(STOP_O),
	.WAIT_O(WAIT_O), .ACTIVE_O(ACTIVE_O));
